// ### core/pcdam_consts.svh
// Constants for the port C and port D alternate-function override block.
`ifndef PCDAM_CONSTS_SVH
`define PCDAM_CONSTS_SVH

// ****************************************************************
// Pin counts and positions
// ****************************************************************
`define PCDAM_PC_W 7
`define PCDAM_PD_W 8
`define PCDAM_NPINS 15
`define PCDAM_PD_BASE 7
`define PCDAM_PC_RESET 6
`define PCDAM_PC_SCL 5
`define PCDAM_PC_SDA 4
`define PCDAM_PD_T1 5
`define PCDAM_PD_XCK 4
`define PCDAM_PD_EXT_IRQ_ONE_PIN 3
`define PCDAM_PD_EXT_IRQ_ZERO_PIN 2
`define PCDAM_PD_TXD 1
`define PCDAM_PD_RXD 0

// ****************************************************************
// Timing and reset values
// ****************************************************************
`define PCDAM_CLK_PERIOD_NS 10
`define PCDAM_SPIKE_NS 50
`define PCDAM_SPIKE_CYCLES \
  ((`PCDAM_SPIKE_NS + `PCDAM_CLK_PERIOD_NS - 1) / `PCDAM_CLK_PERIOD_NS)
`define PCDAM_SYNC_RST 1'b1
`define PCDAM_RST_IDLE 1'b1

`endif

// ### core/pcdam_pkg.sv
// Types shared by the port C and port D override block.
`include "pcdam_consts.svh"
package pcdam_pkg;
  typedef logic [`PCDAM_NPINS-1:0] pcdam_pins_t;
  typedef logic [2:0] pcdam_filt_cnt_t;
endpackage

// ### core/pcdam_top.sv
// Alternate-function override logic for port C and port D pins.
//
// Contract
// - Fuse programmed: bit C6 is plain I/O; unprogrammed: pin feeds reset.
// - While C6 is reset, its direction, output and input reads give zero.
// - Two-wire enable hands bit C5 to the two-wire clock line.
// - Two-wire enable hands bit C4 to the two-wire data line.
// - Two-wire lines filter spikes under 50 ns, drive open-drain, slew-limited.
// - Spike filter sits before two-wire logic; slew limit follows the enable.
// - C6: fuse enables pull-up, direction, input overrides; pull-up value one.
// - C5, C4: enable overrides pull-up, direction, output; output value zero.
// - Bits C3 to C0 carry no overrides; they keep their plain digital port I/O.
// - D7 to D5 unoverridden; D5 feeds counter one external input.
// - D4 output override follows sync select; input feeds clock and counter0.
// - Interrupt enables force digital input on for D3 and D2.
// - Transmitter enabled forces bit D1 to output.
// - Receiver enabled forces bit D0 to input; pull-up follows its port bit.
// - Transmit and receive enables set D1 and D0 override enables and values.
`timescale 1ns/1ps
`default_nettype none
`include "pcdam_consts.svh"

module pcdam_top
  import pcdam_pkg::*;
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic reset_pin_disable_fuse_in,
  input wire logic two_wire_enable_in,
  input wire logic global_pullup_disable_in,
  input wire logic [`PCDAM_PC_W-1:0] port_c_output_in,
  input wire logic [`PCDAM_PC_W-1:0] port_c_direction_in,
  input wire logic [`PCDAM_PD_W-1:0] port_d_output_in,
  input wire logic [`PCDAM_PD_W-1:0] port_d_direction_in,
  input wire logic [`PCDAM_PC_W-1:0] port_c_pin_in,
  input wire logic [`PCDAM_PD_W-1:0] port_d_pin_in,
  input wire logic two_wire_clock_drive_in,
  input wire logic two_wire_data_drive_in,
  input wire logic usart_sync_select_in,
  input wire logic usart_clock_drive_in,
  input wire logic transmit_enable_in,
  input wire logic transmit_data_in,
  input wire logic receive_enable_in,
  input wire logic ext_irq_zero_enable_in,
  input wire logic ext_irq_one_enable_in,
  output logic [`PCDAM_PC_W-1:0] port_c_pin_out,
  output logic [`PCDAM_PC_W-1:0] port_c_pin_oe_out,
  output logic [`PCDAM_PC_W-1:0] port_c_pullup_out,
  output logic [`PCDAM_PD_W-1:0] port_d_pin_out,
  output logic [`PCDAM_PD_W-1:0] port_d_pin_oe_out,
  output logic [`PCDAM_PD_W-1:0] port_d_pullup_out,
  output logic [1:0] two_wire_slew_limit_out,
  output logic [`PCDAM_PC_W-1:0] port_c_direction_read_out,
  output logic [`PCDAM_PC_W-1:0] port_c_output_read_out,
  output logic [`PCDAM_PC_W-1:0] port_c_input_read_out,
  output logic [`PCDAM_PD_W-1:0] port_d_input_read_out,
  output logic reset_pin_level_out,
  output logic two_wire_clock_sense_out,
  output logic two_wire_data_sense_out,
  output logic counter1_external_input_out,
  output logic counter0_external_input_out,
  output logic usart_external_clock_out,
  output logic ext_irq_zero_pin_out,
  output logic ext_irq_one_pin_out,
  output logic receive_data_out
);

  // ****************************************************************
  // Pin indices in the joined C/D vector
  // ****************************************************************
  localparam int RST = `PCDAM_PC_RESET;
  localparam int SCL = `PCDAM_PC_SCL;
  localparam int SDA = `PCDAM_PC_SDA;
  localparam int T1 = `PCDAM_PD_BASE + `PCDAM_PD_T1;
  localparam int USART_EXTERNAL_CLOCK = `PCDAM_PD_BASE + `PCDAM_PD_XCK;
  localparam int IRQ1 = `PCDAM_PD_BASE + `PCDAM_PD_EXT_IRQ_ONE_PIN;
  localparam int IRQ0 = `PCDAM_PD_BASE + `PCDAM_PD_EXT_IRQ_ZERO_PIN;
  localparam int TXD = `PCDAM_PD_BASE + `PCDAM_PD_TXD;
  localparam int RXD = `PCDAM_PD_BASE + `PCDAM_PD_RXD;
  localparam pcdam_filt_cnt_t SPIKE_LAST =
    pcdam_filt_cnt_t'(`PCDAM_SPIKE_CYCLES - 1);

  // Override when enabled, otherwise the normal port setting.
  function automatic logic pcdam_pick(input logic en, input logic ov,
                                      input logic norm);
    pcdam_pick = en ? ov : norm;
  endfunction

  pcdam_pins_t norm_port, norm_dir, pins_raw;
  pcdam_pins_t pullup_override_enable, pullup_override_value;
  pcdam_pins_t direction_override_enable, direction_override_value;
  pcdam_pins_t output_value_override_enable, output_value_override_value;
  pcdam_pins_t input_enable_override_enable, input_enable_override_value;
  pcdam_pins_t eff_dir, eff_val, eff_pu, eff_die;
  pcdam_pins_t sync1, sync2, sync3, accepted, din;
  pcdam_pins_t pin_q, oe_q, pu_q;
  logic [1:0] filt;
  logic [1:0] filt_raw;
  pcdam_filt_cnt_t filt_cnt [2];
  logic global_pullup_disable;

  assign norm_port = {port_d_output_in, port_c_output_in};
  assign norm_dir = {port_d_direction_in, port_c_direction_in};
  assign pins_raw = {port_d_pin_in, port_c_pin_in};
  assign global_pullup_disable = global_pullup_disable_in;

  // ****************************************************************
  // Override tables
  // ****************************************************************
  // Pins not named here keep every enable and value at zero.
  always_comb begin
    pullup_override_enable = '0;
    pullup_override_value = '0;
    direction_override_enable = '0;
    direction_override_value = '0;
    output_value_override_enable = '0;
    output_value_override_value = '0;
    input_enable_override_enable = '0;
    input_enable_override_value = '0;
    // Reset pin: fuse value 1 (unprogrammed) hands it to reset.
    pullup_override_enable[RST] = reset_pin_disable_fuse_in;
    pullup_override_value[RST] = 1'b1;
    direction_override_enable[RST] = reset_pin_disable_fuse_in;
    input_enable_override_enable[RST] = reset_pin_disable_fuse_in;
    // Two-wire pins: open-drain, drive low means output enabled.
    pullup_override_enable[SCL] = two_wire_enable_in;
    pullup_override_enable[SDA] = two_wire_enable_in;
    pullup_override_value[SCL] = norm_port[SCL] & ~global_pullup_disable;
    pullup_override_value[SDA] = norm_port[SDA] & ~global_pullup_disable;
    direction_override_enable[SCL] = two_wire_enable_in;
    direction_override_enable[SDA] = two_wire_enable_in;
    direction_override_value[SCL] = two_wire_clock_drive_in;
    direction_override_value[SDA] = two_wire_data_drive_in;
    output_value_override_enable[SCL] = two_wire_enable_in;
    output_value_override_enable[SDA] = two_wire_enable_in;
    // USART clock output in synchronous mode.
    output_value_override_enable[USART_EXTERNAL_CLOCK] = usart_sync_select_in;
    output_value_override_value[USART_EXTERNAL_CLOCK] = usart_clock_drive_in;
    // Interrupt pins keep their input sampled.
    input_enable_override_enable[IRQ0] = ext_irq_zero_enable_in;
    input_enable_override_enable[IRQ1] = ext_irq_one_enable_in;
    input_enable_override_value[IRQ0] = 1'b1;
    input_enable_override_value[IRQ1] = 1'b1;
    // USART data pins.
    pullup_override_enable[TXD] = transmit_enable_in;
    direction_override_enable[TXD] = transmit_enable_in;
    direction_override_value[TXD] = 1'b1;
    output_value_override_enable[TXD] = transmit_enable_in;
    output_value_override_value[TXD] = transmit_data_in;
    pullup_override_enable[RXD] = receive_enable_in;
    pullup_override_value[RXD] = norm_port[RXD] & ~global_pullup_disable;
    direction_override_enable[RXD] = receive_enable_in;
  end

  // ****************************************************************
  // Per-pin selection and input synchronisers
  // ****************************************************************
  // Three stages per pin; a new level is taken once stages two and three
  // agree, so a one-cycle metastable blip never reaches the logic.
  for (genvar i = 0; i < `PCDAM_NPINS; i++) begin : g_pin
    assign eff_dir[i] = pcdam_pick(direction_override_enable[i],
                                   direction_override_value[i],
                                   norm_dir[i]);
    assign eff_val[i] = pcdam_pick(output_value_override_enable[i],
                                   output_value_override_value[i],
                                   norm_port[i]);
    assign eff_pu[i] = pcdam_pick(pullup_override_enable[i],
                                  pullup_override_value[i],
                                  norm_port[i] & ~norm_dir[i] & ~global_pullup_disable);
    assign eff_die[i] = pcdam_pick(input_enable_override_enable[i],
                                   input_enable_override_value[i],
                                   1'b1);
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        sync1[i] <= `PCDAM_SYNC_RST;
        sync2[i] <= `PCDAM_SYNC_RST;
        sync3[i] <= `PCDAM_SYNC_RST;
        accepted[i] <= `PCDAM_SYNC_RST;
      end else begin
        sync1[i] <= pins_raw[i];
        sync2[i] <= sync1[i];
        sync3[i] <= sync2[i];
        if (sync2[i] == sync3[i]) begin
          accepted[i] <= sync3[i];
        end
      end
    end
  end
  // A disabled digital input reads low, which also blanks the reset pin's input read-back.
  assign din = accepted & eff_die;

  // ****************************************************************
  // Two-wire spike filters
  // ****************************************************************
  // A level must differ from the filtered one for the whole spike time
  // before it passes; shorter pulses restart the count.
  assign filt_raw = {accepted[SDA], accepted[SCL]};
  for (genvar j = 0; j < 2; j++) begin : g_filt
    always_ff @(posedge clk_in) begin
      if (!reset_n_in) begin
        filt[j] <= `PCDAM_RST_IDLE;
        filt_cnt[j] <= '0;
      end else if (filt_raw[j] == filt[j]) begin
        filt_cnt[j] <= '0;
      end else if (filt_cnt[j] == SPIKE_LAST) begin
        filt[j] <= filt_raw[j];
        filt_cnt[j] <= '0;
      end else begin
        filt_cnt[j] <= filt_cnt[j] + 1'b1;
      end
    end
  end

  // ****************************************************************
  // Registered pin drive
  // ****************************************************************
  // Registering costs one cycle of latency but keeps the pads glitch free.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pin_q <= '0;
      oe_q <= '0;
      pu_q <= '0;
      two_wire_slew_limit_out <= '0;
    end else begin
      pin_q <= eff_val;
      oe_q <= eff_dir;
      pu_q <= eff_pu;
      two_wire_slew_limit_out <= {2{two_wire_enable_in}};
    end
  end
  assign port_c_pin_out = pin_q[`PCDAM_PC_W-1:0];
  assign port_c_pin_oe_out = oe_q[`PCDAM_PC_W-1:0];
  assign port_c_pullup_out = pu_q[`PCDAM_PC_W-1:0];
  assign port_d_pin_out = pin_q[`PCDAM_NPINS-1:`PCDAM_PD_BASE];
  assign port_d_pin_oe_out = oe_q[`PCDAM_NPINS-1:`PCDAM_PD_BASE];
  assign port_d_pullup_out = pu_q[`PCDAM_NPINS-1:`PCDAM_PD_BASE];

  // ****************************************************************
  // Register read-back
  // ****************************************************************
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      port_c_direction_read_out <= '0;
      port_c_output_read_out <= '0;
      port_c_input_read_out <= '0;
      port_d_input_read_out <= '0;
    end else begin
      port_c_direction_read_out <= port_c_direction_in;
      port_c_output_read_out <= port_c_output_in;
      port_c_input_read_out <= din[`PCDAM_PC_W-1:0];
      port_d_input_read_out <= din[`PCDAM_NPINS-1:`PCDAM_PD_BASE];
      if (reset_pin_disable_fuse_in) begin
        port_c_direction_read_out[RST] <= 1'b0;
        port_c_output_read_out[RST] <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Peripheral inputs
  // ****************************************************************
  // Analog paths (ADC channels, comparator) bypass this digital logic.
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      reset_pin_level_out <= `PCDAM_RST_IDLE;
      two_wire_clock_sense_out <= `PCDAM_RST_IDLE;
      two_wire_data_sense_out <= `PCDAM_RST_IDLE;
      counter1_external_input_out <= 1'b0;
      counter0_external_input_out <= 1'b0;
      usart_external_clock_out <= 1'b0;
      ext_irq_zero_pin_out <= 1'b0;
      ext_irq_one_pin_out <= 1'b0;
      receive_data_out <= 1'b0;
    end else begin
      reset_pin_level_out <= reset_pin_disable_fuse_in ? accepted[RST] :
                             `PCDAM_RST_IDLE;
      two_wire_clock_sense_out <= two_wire_enable_in ? filt[0] :
                                  `PCDAM_RST_IDLE;
      two_wire_data_sense_out <= two_wire_enable_in ? filt[1] :
                                 `PCDAM_RST_IDLE;
      counter1_external_input_out <= din[T1];
      counter0_external_input_out <= din[USART_EXTERNAL_CLOCK];
      usart_external_clock_out <= din[USART_EXTERNAL_CLOCK];
      ext_irq_zero_pin_out <= din[IRQ0];
      ext_irq_one_pin_out <= din[IRQ1];
      receive_data_out <= din[RXD];
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  sequence scl_low_run;
    (filt[0] && !filt_raw[0]) ##1 (!filt_raw[0])[*4];
  endsequence

  reset_pin_mode_a: assert property (
    reset_pin_disable_fuse_in [*2] |-> !port_c_pin_oe_out[RST] &&
      port_c_pullup_out[RST] && reset_pin_level_out == $past(accepted[RST]))
    else $error("reset pin not held as reset input");
  reset_pin_read_a: assert property (
    $past(reset_pin_disable_fuse_in) |-> !port_c_input_read_out[RST] &&
      !port_c_direction_read_out[RST] && !port_c_output_read_out[RST])
    else $error("reset pin read-back not zero");
  twi_open_drain_a: assert property (
    two_wire_enable_in |=> !port_c_pin_out[SCL] && !port_c_pin_out[SDA] &&
      port_c_pin_oe_out[SCL] == $past(two_wire_clock_drive_in) &&
      port_c_pin_oe_out[SDA] == $past(two_wire_data_drive_in))
    else $error("two-wire pins not open-drain");
  spike_pass_a: assert property (
    scl_low_run |=> !filt[0])
    else $error("long low level not passed by filter");
  spike_block_a: assert property (
    $fell(filt[0]) |-> $past(!filt_raw[0], 1) && $past(!filt_raw[0], 5))
    else $error("short spike passed by filter");
  slew_follow_a: assert property (
    $rose(two_wire_enable_in) |=> two_wire_slew_limit_out == 2'b11)
    else $error("slew limit not enabled with interface");
  adc_pins_free_a: assert property (
    port_c_pin_oe_out[3:0] == $past(port_c_direction_in[3:0]) &&
    port_c_pin_out[3:0] == $past(port_c_output_in[3:0]))
    else $error("ADC pins overridden");
  xck_drive_a: assert property (
    usart_sync_select_in |=> port_d_pin_out[`PCDAM_PD_XCK] ==
      $past(usart_clock_drive_in))
    else $error("USART clock not driven in sync mode");
  irq_sample_a: assert property (
    ext_irq_zero_enable_in [*2] |=> ext_irq_zero_pin_out == $past(accepted[IRQ0]))
    else $error("interrupt input not sampled");
  tx_force_a: assert property (
    transmit_enable_in |=> port_d_pin_oe_out[`PCDAM_PD_TXD] &&
      !port_d_pullup_out[`PCDAM_PD_TXD] &&
      port_d_pin_out[`PCDAM_PD_TXD] == $past(transmit_data_in))
    else $error("transmit pin not forced to output");
  rx_force_a: assert property (
    receive_enable_in |=> !port_d_pin_oe_out[`PCDAM_PD_RXD] &&
      port_d_pullup_out[`PCDAM_PD_RXD] ==
      $past(port_d_output_in[`PCDAM_PD_RXD] & ~global_pullup_disable_in))
    else $error("receive pin not forced to input");

endmodule // pcdam_top
`default_nettype wire

// ### verif/pcdam_pad_model.sv
// Pad model for the outside of the port C and port D pins.
`timescale 1ns/1ps
`default_nettype none
`include "pcdam_consts.svh"

module pcdam_pad_model
  import pcdam_pkg::*;
(
  input wire logic clk_in,
  input wire logic [`PCDAM_PC_W-1:0] c_drive_in,
  input wire logic [`PCDAM_PC_W-1:0] c_oe_in,
  input wire logic [`PCDAM_PC_W-1:0] c_pullup_in,
  input wire logic [`PCDAM_PD_W-1:0] d_drive_in,
  input wire logic [`PCDAM_PD_W-1:0] d_oe_in,
  input wire logic [`PCDAM_PD_W-1:0] d_pullup_in,
  input wire pcdam_pins_t ext_en_in,
  input wire pcdam_pins_t ext_val_in,
  output logic [`PCDAM_PC_W-1:0] c_pad_out,
  output logic [`PCDAM_PD_W-1:0] d_pad_out
);
  pcdam_pins_t churn = 15'h5555;
  pcdam_pins_t oe_all;
  pcdam_pins_t pu_all;
  pcdam_pins_t pad_all;

  // A floating pad flips every cycle, so it never looks like a steady level.
  always_ff @(posedge clk_in) begin
    churn <= ~churn;
  end

  // The two-wire lines carry an outside bus pull-up, so an open-drain
  // release reads high there; a pad driven by the chip wins over all else.
  assign oe_all = {d_oe_in, c_oe_in};
  assign pu_all = {d_pullup_in, c_pullup_in} | 15'h0030;
  assign pad_all = (oe_all & {d_drive_in, c_drive_in}) |
    (~oe_all & ext_en_in & ext_val_in) |
    (~oe_all & ~ext_en_in & (pu_all | churn));
  assign c_pad_out = pad_all[`PCDAM_PC_W-1:0];
  assign d_pad_out = pad_all[`PCDAM_NPINS-1:`PCDAM_PD_BASE];
endmodule // pcdam_pad_model
`default_nettype wire

// ### verif/pcdam_top_test.sv
// Self-checking bench for the port C and port D override block.
`timescale 1ns/1ps
`default_nettype none
`include "pcdam_consts.svh"

module pcdam_top_test import pcdam_pkg::*;;
  // ****************************************************************
  // Signals and cases
  // ****************************************************************
  typedef struct {
    logic [9:0] ctl;
    logic [6:0] c_out, c_dir;
    logic [7:0] d_out, d_dir;
    logic [6:0] c_oe, c_pu, c_val;
    logic [7:0] d_oe, d_pu, d_val;
    logic [1:0] slew;
  } pcdam_row_t;
  logic clk_in = 1'b0;
  logic reset_n_in, reset_pin_disable_fuse_in, two_wire_enable_in;
  logic global_pullup_disable_in, two_wire_clock_drive_in;
  logic two_wire_data_drive_in, usart_sync_select_in, usart_clock_drive_in;
  logic transmit_enable_in, transmit_data_in, receive_enable_in;
  logic ext_irq_zero_enable_in, ext_irq_one_enable_in;
  logic [6:0] port_c_output_in, port_c_direction_in, port_c_pin_in;
  logic [7:0] port_d_output_in, port_d_direction_in, port_d_pin_in;
  logic [6:0] port_c_pin_out, port_c_pin_oe_out, port_c_pullup_out, c_drv;
  logic [7:0] port_d_pin_out, port_d_pin_oe_out, port_d_pullup_out, d_drv;
  logic [1:0] two_wire_slew_limit_out;
  logic [6:0] port_c_direction_read_out, port_c_output_read_out;
  logic [6:0] port_c_input_read_out;
  logic [7:0] port_d_input_read_out;
  logic reset_pin_level_out, two_wire_clock_sense_out;
  logic two_wire_data_sense_out, counter1_external_input_out;
  logic counter0_external_input_out, usart_external_clock_out;
  logic ext_irq_zero_pin_out, ext_irq_one_pin_out, receive_data_out;
  pcdam_pins_t ext_en, ext_val;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] pat[2] = '{8'haa, 8'h55};
  // Control order: fuse, two-wire, pull-up off, clock drive, data drive,
  // sync select, clock value, transmit, transmit data, receive.
  pcdam_row_t rows[9] = '{
    '{10'h000, 7'h55, 7'h0f, 8'ha5, 8'h3c, 7'h0f, 7'h50, 7'h05, 8'h3c,
      8'h81, 8'h24, 2'h0},
    '{10'h080, 7'h55, 7'h0f, 8'ha5, 8'h3c, 7'h0f, 7'h00, 7'h05, 8'h3c,
      8'h00, 8'h24, 2'h0},
    '{10'h340, 7'h3f, 7'h4f, 8'h00, 8'h00, 7'h2f, 7'h70, 7'h0f, 8'h00,
      8'h00, 8'h00, 2'h3},
    '{10'h01f, 7'h00, 7'h00, 8'h01, 8'h11, 7'h00, 7'h00, 7'h00, 8'h12,
      8'h01, 8'h12, 2'h0},
    '{10'h015, 7'h00, 7'h00, 8'hfe, 8'h10, 7'h00, 7'h00, 7'h00, 8'h12,
      8'hec, 8'h00, 2'h0},
    '{10'h008, 7'h00, 7'h00, 8'h00, 8'h10, 7'h00, 7'h00, 7'h00, 8'h10,
      8'h00, 8'h00, 2'h0},
    '{10'h081, 7'h00, 7'h00, 8'h01, 8'h01, 7'h00, 7'h00, 7'h00, 8'h00,
      8'h00, 8'h00, 2'h0},
    '{10'h1a0, 7'h30, 7'h20, 8'h00, 8'h00, 7'h10, 7'h00, 7'h00, 8'h00,
      8'h00, 8'h00, 2'h3},
    '{10'h100, 7'h30, 7'h30, 8'h00, 8'h00, 7'h00, 7'h30, 7'h00, 8'h00,
      8'h00, 8'h00, 2'h3}};

  // Pad values only mean something where the pin is driven.
  assign c_drv = port_c_pin_out & port_c_pin_oe_out;
  assign d_drv = port_d_pin_out & port_d_pin_oe_out;

  pcdam_top u_pcdam_top (.*);

  pcdam_pad_model u_pcdam_pad_model (.clk_in(clk_in),
    .c_drive_in(port_c_pin_out), .c_oe_in(port_c_pin_oe_out),
    .c_pullup_in(port_c_pullup_out), .d_drive_in(port_d_pin_out),
    .d_oe_in(port_d_pin_oe_out), .d_pullup_in(port_d_pullup_out),
    .ext_en_in(ext_en), .ext_val_in(ext_val),
    .c_pad_out(port_c_pin_in), .d_pad_out(port_d_pin_in));

  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_in = ~clk_in;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check_vec(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  task automatic set_ctl(input logic [9:0] c);
    {reset_pin_disable_fuse_in, two_wire_enable_in, global_pullup_disable_in,
     two_wire_clock_drive_in, two_wire_data_drive_in, usart_sync_select_in,
     usart_clock_drive_in, transmit_enable_in, transmit_data_in,
     receive_enable_in} = c;
  endtask

  task automatic set_ports(input logic [6:0] co, cd, input logic [7:0] dd_o,
                           input logic [7:0] dd_d);
    port_c_output_in = co;
    port_c_direction_in = cd;
    port_d_output_in = dd_o;
    port_d_direction_in = dd_d;
  endtask

  function automatic logic sense(input int ln);
    return (ln == 5) ? two_wire_clock_sense_out : two_wire_data_sense_out;
  endfunction

  // A wait that runs out is reported and ends the run at once.
  task automatic wait_sense(input int ln, input logic lvl, input int bound);
    int n = 0;
    while (sense(ln) !== lvl && n < bound) begin
      cycles(1);
      n++;
    end
    check_bit(sense(ln), lvl, "filtered line");
    if (sense(ln) !== lvl) begin
      give_verdict();
    end
  endtask

  // Main sequence: reset, table of cases, then the awkward cases.
  initial begin
    reset_n_in = 1'b0;
    set_ctl(10'h000);
    set_ports(7'h00, 7'h00, 8'h00, 8'h00);
    ext_irq_zero_enable_in = 1'b0;
    ext_irq_one_enable_in = 1'b0;
    ext_en = '0;
    ext_val = '0;
    cycles(10);
    check_bit(reset_pin_level_out, 1'b1, "reset level in reset");
    check_bit(two_wire_clock_sense_out, 1'b1, "clock sense in reset");
    check_vec(8'(port_d_pin_oe_out), 8'h00, "d oe in reset");
    reset_n_in = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      set_ctl(rows[i].ctl);
      set_ports(rows[i].c_out, rows[i].c_dir, rows[i].d_out, rows[i].d_dir);
      cycles(1);
      check_vec(8'(port_c_pin_oe_out), 8'(rows[i].c_oe), "c oe");
      check_vec(8'(port_c_pullup_out), 8'(rows[i].c_pu), "c pu");
      check_vec(8'(c_drv), 8'(rows[i].c_val), "c drive");
      check_vec(port_d_pin_oe_out, rows[i].d_oe, "d oe");
      check_vec(port_d_pullup_out, rows[i].d_pu, "d pu");
      check_vec(d_drv, rows[i].d_val, "d drive");
      check_vec(8'(two_wire_slew_limit_out), 8'(rows[i].slew), "slew");
    end
    $display("test table done");
    set_ctl(10'h200);
    set_ports(7'h40, 7'h40, 8'h00, 8'h00);
    ext_en = 15'h0040;
    cycles(6);
    check_vec(8'(port_c_direction_read_out), 8'h00, "dir read");
    check_vec(8'(port_c_output_read_out), 8'h00, "out read");
    check_bit(reset_pin_level_out, 1'b0, "reset pin low");
    ext_val = 15'h0040;
    cycles(6);
    check_bit(port_c_input_read_out[6], 1'b0, "pin read");
    check_bit(reset_pin_level_out, 1'b1, "reset pin high");
    ext_en = '0;
    set_ctl(10'h000);
    cycles(6);
    check_vec(8'(port_c_direction_read_out), 8'h40, "dir read io");
    check_vec(8'(port_c_output_read_out), 8'h40, "out read io");
    check_bit(port_c_input_read_out[6], 1'b1, "pin read io");
    $display("test reset pin done");
    // Comparator pins stay inputs without pull-up here.
    set_ctl(10'h001);
    set_ports(7'h00, 7'h00, 8'h00, 8'h01);
    ext_irq_zero_enable_in = 1'b1;
    ext_irq_one_enable_in = 1'b1;
    ext_en = 15'h7f80;
    foreach (pat[k]) begin
      ext_val = {pat[k], 7'h00};
      cycles(6);
      check_vec(port_d_input_read_out, pat[k], "d read");
      check_bit(counter1_external_input_out, pat[k][5], "t1");
      check_bit(counter0_external_input_out, pat[k][4], "t0");
      check_bit(usart_external_clock_out, pat[k][4], "xck");
      check_bit(ext_irq_one_pin_out, pat[k][3], "irq1");
      check_bit(ext_irq_zero_pin_out, pat[k][2], "irq0");
      check_bit(receive_data_out, pat[k][0], "rxd");
    end
    $display("test pin inputs done");
    set_ctl(10'h100);
    set_ports(7'h00, 7'h00, 8'h00, 8'h00);
    ext_en = 15'h0030;
    ext_val = 15'h0030;
    cycles(12);
    for (int ln = 4; ln <= 5; ln++) begin
      ext_val[ln] = 1'b0;
      cycles(4);
      ext_val[ln] = 1'b1;
      repeat (12) begin
        cycles(1);
        check_bit(sense(ln), 1'b1, "short spike");
      end
      ext_val[ln] = 1'b0;
      cycles(5);
      ext_val[ln] = 1'b1;
      wait_sense(ln, 1'b0, 12);
      wait_sense(ln, 1'b1, 16);
    end
    ext_en = '0;
    set_ctl(10'h160);
    wait_sense(5, 1'b0, 16);
    wait_sense(4, 1'b0, 16);
    check_vec(8'(c_drv), 8'h00, "open drain low");
    set_ctl(10'h000);
    ext_en = 15'h0030;
    ext_val = '0;
    cycles(12);
    check_bit(two_wire_clock_sense_out, 1'b1, "clock sense off");
    check_bit(two_wire_data_sense_out, 1'b1, "data sense off");
    $display("test two-wire done");
    give_verdict();
  end
endmodule // pcdam_top_test
`default_nettype wire
